// ### core/uosp_sync.sv
// two flop synchroniser for the asynchronous comparator and line inputs
// assumes asynchronous active high reset
`timescale 1ns/1ps
module uosp_sync
   import uosp_pkg::*;
(
   // clock and reset
   input  wire logic core_clk,
   input  wire logic rst,
   // signal bundle
   uosp_sync_if.src  sig
);
   logic [SYNC_WIDTH-1:0] meta_reg;
   logic [SYNC_WIDTH-1:0] sync_reg;

   // first stage feeds only the second [R14]
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= sig.raw;
         sync_reg <= meta_reg;
      end
   end
   assign sig.synced = sync_reg;
endmodule : uosp_sync

// ### core/uosp_top.sv
// otg status and power control registers with line stability timer
// assumes transceiver inputs asynchronous; register port single cycle
`timescale 1ns/1ps
module uosp_top
   import uosp_pkg::*;
#(
   parameter int STABLE_COUNT = STABLE_CYCLES
)(
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst,
   // register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   // transceiver and comparators
   input  wire logic        id_pin,
   input  wire logic        se0_line,
   input  wire logic        j_line,
   input  wire logic        vbus_above_sess,
   input  wire logic        b_role,
   input  wire logic        bus_activity,
   input  wire logic        core_active,
   // interrupt handshake from the usb core
   input  wire logic        act_irq_done,
   // power and clock control
   output logic             usb_clk_gate_en,
   output logic             xcvr_low_power,
   output logic             usb_pins_owned,
   output logic             analog_enable,
   output logic             sleep_block
);
   typedef enum logic [1:0] {
      UOSP_OFF      = 2'b00,
      UOSP_ON       = 2'b01,
      UOSP_DRAINING = 2'b11
   } uosp_pwr_type;

   uosp_sync_if sync_bus ();
   uosp_sync u_sync (
      .core_clk (core_clk),
      .rst      (rst),
      .sig      (sync_bus.src)
   );
   assign sync_bus.raw = {core_active, bus_activity, b_role, vbus_above_sess,
                          j_line, se0_line, id_pin};

   wire id_s        = sync_bus.synced[0];
   wire se0_s       = sync_bus.synced[1];
   wire j_s         = sync_bus.synced[2];
   wire vbus_s      = sync_bus.synced[3];
   wire brole_s     = sync_bus.synced[4];
   wire activity_s  = sync_bus.synced[5];
   wire active_s    = sync_bus.synced[6];

   // register state
   logic        enable_reg,  enable_next;
   logic        suspend_reg, suspend_next;
   logic        guard_reg,   guard_next;
   logic        pend_reg,    pend_next;
   logic        busy_reg,    busy_next;
   logic [31:0] rdata_reg,   rdata_next;
   logic        stable_reg,  stable_next;
   logic [31:0] stab_cnt_reg, stab_cnt_next;
   logic [1:0]  line_prev_reg;
   logic [3:0]  drain_cnt_reg, drain_cnt_next;
   uosp_pwr_type pwr_reg, pwr_next;
   logic        clk_en_reg, lowpwr_reg, pins_reg, analog_reg, sleep_reg;

   // decode
   wire wr_status  = reg_wr && (reg_addr == OTG_STATUS_OFFSET);
   wire wr_power   = reg_wr && (reg_addr == POWER_CTRL_OFFSET);
   wire rd_status  = reg_rd && (reg_addr == OTG_STATUS_OFFSET);
   wire rd_power   = reg_rd && (reg_addr == POWER_CTRL_OFFSET);

   // line state stability timer
   wire [1:0] line_now     = {j_s, se0_s};
   wire       line_changed = (line_now != line_prev_reg);
   wire       stab_done    = (stab_cnt_reg >= STABLE_COUNT[31:0] - 32'h0000_0001);
   assign stab_cnt_next = line_changed ? 32'h0000_0000
                        : (stab_done ? stab_cnt_reg : stab_cnt_reg + 32'h0000_0001);
   assign stable_next   = !line_changed && stab_done;                        // [R2]

   // status word; unimplemented bits are zero
   wire [31:0] status_word = 32'h0000_0000
      | ({31'h0000_0000, id_s}                   << CABLE_BIT)               // [R1]
      | ({31'h0000_0000, stable_reg}             << LINE_STABLE_BIT)         // [R2]
      | ({31'h0000_0000, vbus_s}                 << SESSION_VALID_BIT)       // [R3]
      | ({31'h0000_0000, brole_s && !vbus_s}     << B_SESS_END_BIT)          // [R4]
      | ({31'h0000_0000, !brole_s && vbus_s}     << A_VBUS_VALID_BIT);       // [R5]
   wire [31:0] power_word = 32'h0000_0000                                   // [R12]
      | ({31'h0000_0000, pend_reg}    << ACT_PEND_BIT)
      | ({31'h0000_0000, guard_reg}   << SLEEP_GUARD_BIT)
      | ({31'h0000_0000, busy_reg}    << BUSY_BIT)
      | ({31'h0000_0000, suspend_reg} << SUSPEND_BIT)
      | ({31'h0000_0000, enable_reg}  << ENABLE_BIT);
   assign rdata_next = rd_status ? status_word
                     : (rd_power ? power_word : 32'h0000_0000);

   // control bits; status register writes and read-only bits are dropped
   assign enable_next  = wr_power ? reg_wdata[ENABLE_BIT]      : enable_reg;  // [R13] [R15]
   assign suspend_next = wr_power ? reg_wdata[SUSPEND_BIT]     : suspend_reg;
   assign guard_next   = wr_power ? reg_wdata[SLEEP_GUARD_BIT] : guard_reg;

   // activity pending: set wins over the clear
   assign pend_next = (enable_reg && activity_s) ? 1'b1
                    : (act_irq_done ? 1'b0 : pend_reg);                       // [R6]

   // power sequencer: drain time after disable before the sequencer returns to off
   always_comb begin
      pwr_next       = pwr_reg;
      drain_cnt_next = drain_cnt_reg;
      unique case (pwr_reg)
         UOSP_OFF: begin
            if (enable_reg) pwr_next = UOSP_ON;
         end
         UOSP_ON: begin
            if (!enable_reg) begin
               pwr_next       = UOSP_DRAINING;
               drain_cnt_next = 4'(BUSY_HOLD_CYCLES - 1);
            end
         end
         UOSP_DRAINING: begin
            // re-enable during the drain goes straight back on; the next
            // disable then restarts the full hold
            if (enable_reg) pwr_next = UOSP_ON;
            else if (drain_cnt_reg != 4'h0) drain_cnt_next = drain_cnt_reg - 4'h1;
            else if (!active_s) pwr_next = UOSP_OFF;
         end
         default: pwr_next = UOSP_OFF;
      endcase
   end
   assign busy_next = (pwr_next != UOSP_OFF) || active_s;                   // [R8]

   // software controls and pending flag
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         enable_reg  <= 1'b0;
         suspend_reg <= 1'b0;
         guard_reg   <= 1'b0;
         pend_reg    <= 1'b0;
         busy_reg    <= 1'b0;
      end else begin
         enable_reg  <= enable_next;
         suspend_reg <= suspend_next;
         guard_reg   <= guard_next;
         pend_reg    <= pend_next;
         busy_reg    <= busy_next;
      end
   end

   // read data stands for one cycle only
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rdata_reg <= REG_RESET;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   // line stability timer
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         stable_reg    <= 1'b0;
         stab_cnt_reg  <= 32'h0000_0000;
         line_prev_reg <= 2'h0;
      end else begin
         stable_reg    <= stable_next;
         stab_cnt_reg  <= stab_cnt_next;
         line_prev_reg <= line_now;
      end
   end

   // power sequencer state
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         drain_cnt_reg <= 4'h0;
         pwr_reg       <= UOSP_OFF;
      end else begin
         drain_cnt_reg <= drain_cnt_next;
         pwr_reg       <= pwr_next;
      end
   end

   // outputs registered
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         clk_en_reg <= 1'b0;
         lowpwr_reg <= 1'b1;
         pins_reg   <= 1'b0;
         analog_reg <= 1'b0;
      end else begin
         clk_en_reg <= enable_next && !suspend_next;                         // [R9] [R10]
         lowpwr_reg <= suspend_next || !enable_next;                         // [R9]
         pins_reg   <= enable_next;                                          // [R10]
         analog_reg <= enable_next;                                          // [R10]
      end
   end

   // sleep entry guard output
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sleep_reg <= 1'b0;
      end else begin
         sleep_reg <= guard_next && (activity_s || pend_next);               // [R7]
      end
   end

   assign reg_rdata       = rdata_reg;
   assign usb_clk_gate_en = clk_en_reg;
   assign xcvr_low_power  = lowpwr_reg;
   assign usb_pins_owned  = pins_reg;
   assign analog_enable   = analog_reg;
   assign sleep_block     = sleep_reg;

   a_pend_set_wins: assert property (@(posedge core_clk) disable iff (rst) // [R6]
      (enable_reg && activity_s) |=> pend_reg)
      else $error("activity pending not set");
   a_sleep_guard_off: assert property (@(posedge core_clk) disable iff (rst) // [R7]
      !guard_reg ##1 !guard_reg |-> !sleep_block)
      else $error("sleep blocked with guard off");
   a_suspend_gates: assert property (@(posedge core_clk) disable iff (rst) // [R9]
      suspend_reg |-> !usb_clk_gate_en && xcvr_low_power)
      else $error("clock not gated in suspend");
   a_disable_release: assert property (@(posedge core_clk) disable iff (rst) // [R10]
      !enable_reg |-> !usb_pins_owned && !analog_enable)
      else $error("pins held while disabled");
   a_busy_after_off: assert property (@(posedge core_clk) disable iff (rst) // [R8]
      $fell(enable_reg) |-> busy_reg [*7])
      else $error("busy dropped too early");
   a_status_read_data: assert property (@(posedge core_clk) disable iff (rst) // [R12]
      reg_rd && reg_addr == OTG_STATUS_OFFSET |=> reg_rdata[31:8] == 24'h00_0000
      && reg_rdata[6] == 1'b0 && reg_rdata[4] == 1'b0 && reg_rdata[1] == 1'b0)
      else $error("reserved status bits nonzero");
   a_stable_clears: assert property (@(posedge core_clk) disable iff (rst) // [R2]
      (line_now != line_prev_reg) |=> !stable_reg)
      else $error("line stable despite change");
   a_sess_end_excl: assert property (@(posedge core_clk) disable iff (rst) // [R4]
      reg_rd && reg_addr == OTG_STATUS_OFFSET |=> !(reg_rdata[3] && reg_rdata[2]))
      else $error("session end and valid together");
   a_ro_write_ignored: assert property (@(posedge core_clk) disable iff (rst) // [R15]
      (reg_wr && reg_addr == OTG_STATUS_OFFSET) |=> $stable(enable_reg))
      else $error("status write changed control");

   // register port answers
   a_rdata_idle: assert property (@(posedge core_clk) disable iff (rst) // [R12]
      !reg_rd |=> reg_rdata == 32'h0000_0000)
      else $error("read data not zero between reads");
   a_power_reserved: assert property (@(posedge core_clk) disable iff (rst) // [R12]
      rd_power |=> reg_rdata[31:8] == 24'h00_0000 && reg_rdata[6:5] == 2'b00
      && reg_rdata[2] == 1'b0)
      else $error("reserved power bits nonzero");
   a_unmapped_zero: assert property (@(posedge core_clk) disable iff (rst) // [R12]
      (reg_rd && !rd_status && !rd_power) |=> reg_rdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   a_write_takes: assert property (@(posedge core_clk) disable iff (rst) // [R13]
      wr_power |=> enable_reg == $past(reg_wdata[ENABLE_BIT])
      && suspend_reg == $past(reg_wdata[SUSPEND_BIT]))
      else $error("control write lost");
   a_other_write: assert property (@(posedge core_clk) disable iff (rst) // [R15]
      (reg_wr && !wr_power) |=> $stable(enable_reg) && $stable(suspend_reg)
      && $stable(guard_reg))
      else $error("controls changed by foreign write");

   // status word fields follow the synchronised inputs
   a_cable_bit: assert property (@(posedge core_clk) disable iff (rst) // [R1]
      rd_status |=> reg_rdata[CABLE_BIT] == $past(id_s))
      else $error("cable type bit wrong");
   a_line_bit: assert property (@(posedge core_clk) disable iff (rst) // [R2]
      rd_status |=> reg_rdata[LINE_STABLE_BIT] == $past(stable_reg))
      else $error("line stable bit wrong");
   a_sess_valid_bit: assert property (@(posedge core_clk) disable iff (rst) // [R3]
      rd_status |=> reg_rdata[SESSION_VALID_BIT] == $past(vbus_s))
      else $error("session valid bit wrong");
   a_b_end_bit: assert property (@(posedge core_clk) disable iff (rst) // [R4]
      rd_status |=> reg_rdata[B_SESS_END_BIT] == $past(brole_s && !vbus_s))
      else $error("session end bit wrong");
   a_a_valid_bit: assert property (@(posedge core_clk) disable iff (rst) // [R5]
      rd_status |=> reg_rdata[A_VBUS_VALID_BIT] == $past(!brole_s && vbus_s))
      else $error("vbus valid bit wrong");

   // pending flag, busy and power outputs
   a_pend_needs_en: assert property (@(posedge core_clk) disable iff (rst) // [R6]
      (!enable_reg && !pend_reg) |=> !pend_reg)
      else $error("pending set while disabled");
   a_pend_clears: assert property (@(posedge core_clk) disable iff (rst) // [R6]
      (act_irq_done && !(enable_reg && activity_s)) |=> !pend_reg)
      else $error("pending not cleared");
   a_guard_blocks: assert property (@(posedge core_clk) disable iff (rst) // [R7]
      (guard_reg && pend_reg) |-> sleep_block)
      else $error("sleep not blocked while pending");
   a_busy_when_on: assert property (@(posedge core_clk) disable iff (rst) // [R8]
      enable_reg |=> busy_reg)
      else $error("busy low while enabled");
   a_drain_busy: assert property (@(posedge core_clk) disable iff (rst) // [R8]
      (pwr_reg == UOSP_DRAINING) |-> busy_reg)
      else $error("busy low while draining");
   a_clk_runs: assert property (@(posedge core_clk) disable iff (rst) // [R9]
      (enable_reg && !suspend_reg) |-> usb_clk_gate_en && !xcvr_low_power)
      else $error("clock gated while running");
   a_pins_owned: assert property (@(posedge core_clk) disable iff (rst) // [R10]
      enable_reg |-> usb_pins_owned && analog_enable)
      else $error("pins not owned while enabled");
endmodule : uosp_top

// ### inc/uosp_pkg.sv
// package for the usb otg status and power control block
// assumes a 200 MHz core clock and a plain strobe-based register port
// Overview of operation
// R1 - cable type bit reads 1 for no cable or B cable, 0 for A cable
// R2 - line stable bit is 1 only if se0 and j were unchanged for 1 ms
// R3 - session valid bit follows vbus above session valid threshold, both roles
// R4 - B session end bit is 1 while vbus below session valid; the code sets it only while b_role is high
// R5 - A vbus valid bit is 1 while vbus above session valid on A device
// R6 - activity pending set on bus activity before interrupt, cleared when none pending
// R7 - sleep guard set blocks sleep on activity or pending notification
// R8 - busy reads 1 while active or not yet ready to re-enable
// R9 - suspend gates the 48 MHz clock and puts transceiver in low power
// R10 - enable off holds outputs inactive, releases pins, shuts analog down; sleep_block is not gated by enable and still follows the sleep guard
// R11 - software ignores status and avoids writes while disabled and busy
// R12 - bits 31 to 8 and unimplemented bits read as zero
// R13 - all bits reset to zero; status read-only, controls read-write
// R14 - asynchronous comparator and line inputs are synchronised before exposure
// R15 - writes to read-only bits have no side effect
package uosp_pkg;
   localparam logic [3:0]  OTG_STATUS_OFFSET  = 4'h0;
   localparam logic [3:0]  POWER_CTRL_OFFSET  = 4'h4;
   localparam int          CABLE_BIT          = 7;
   localparam int          LINE_STABLE_BIT    = 5;
   localparam int          SESSION_VALID_BIT  = 3;
   localparam int          B_SESS_END_BIT     = 2;
   localparam int          A_VBUS_VALID_BIT   = 0;
   localparam int          ACT_PEND_BIT       = 7;
   localparam int          SLEEP_GUARD_BIT    = 4;
   localparam int          BUSY_BIT           = 3;
   localparam int          SUSPEND_BIT        = 1;
   localparam int          ENABLE_BIT         = 0;
   localparam logic [31:0] REG_RESET          = 32'h0000_0000;
   localparam int          CORE_CLK_MHZ       = 200;
   localparam int          STABLE_TIME_US     = 1000;
   localparam int          STABLE_CYCLES      = STABLE_TIME_US * CORE_CLK_MHZ;
   localparam int          BUSY_HOLD_CYCLES   = 8;
   localparam int          SYNC_WIDTH         = 7;
endpackage : uosp_pkg

// ### inc/uosp_sync_if.sv
// bundle of synchronised transceiver inputs
// assumes one clock domain, core_clk
`timescale 1ns/1ps
interface uosp_sync_if;
   import uosp_pkg::*;
   logic [SYNC_WIDTH-1:0] raw;
   logic [SYNC_WIDTH-1:0] synced;
   modport src (input raw, output synced);
   modport dst (output raw, input synced);
endinterface : uosp_sync_if

// ### verif/tb_usb_otg_status_power_ctrl.sv
// self-checking bench for the otg status and power control block
// assumes the cable model on the pins; the register port never waits
`timescale 1ns/1ps
`define CHK(what, exp, got) begin comparisons++; if ((got) !== (exp)) begin err_count++; \
   $display("mismatch %s expected %h seen %h", what, exp, got); end end
module tb_usb_otg_status_power_ctrl;
   import uosp_pkg::*;
   localparam int SC = 16;
   logic        core_clk = 1'b0;
   logic        rst = 1'b1;
   logic [3:0]  reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic        b_cable = 1'b1, role_b = 1'b1, se0 = 1'b0, jst = 1'b1;
   logic        act = 1'b0, busy_core = 1'b0, irq_req = 1'b0;
   logic [15:0] vbus_mv = 16'h0000;
   logic        id_pin, se0_line, j_line, vbus_above_sess, b_role;
   logic        bus_activity, core_active, act_irq_done;
   logic        usb_clk_gate_en, xcvr_low_power, usb_pins_owned, analog_enable, sleep_block;
   int          err_count = 0;
   int          comparisons = 0;
   int          cycles = 0;
   always #2.5 core_clk = ~core_clk;
   uosp_cable_model i_cable (.core_clk(core_clk), .b_cable(b_cable), .role_b(role_b),
      .vbus_mv(vbus_mv), .se0(se0), .jst(jst), .act(act), .busy_core(busy_core),
      .irq_req(irq_req), .id_pin(id_pin), .se0_line(se0_line), .j_line(j_line),
      .vbus_above_sess(vbus_above_sess), .b_role(b_role), .bus_activity(bus_activity),
      .core_active(core_active), .act_irq_done(act_irq_done));
   uosp_top #(.STABLE_COUNT(SC)) i_dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .id_pin(id_pin), .se0_line(se0_line), .j_line(j_line),
      .vbus_above_sess(vbus_above_sess), .b_role(b_role), .bus_activity(bus_activity),
      .core_active(core_active), .act_irq_done(act_irq_done),
      .usb_clk_gate_en(usb_clk_gate_en), .xcvr_low_power(xcvr_low_power),
      .usb_pins_owned(usb_pins_owned), .analog_enable(analog_enable),
      .sleep_block(sleep_block));
   task automatic report_and_stop();
      if (err_count == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : report_and_stop
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask : cyc
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string what);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      `CHK(what, exp, reg_rdata)
   endtask : rd
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         err_count++;
         report_and_stop();
      end
   end
   initial begin
      cyc(3);
      rst <= 1'b0;
      rd(POWER_CTRL_OFFSET, REG_RESET, "power reset");
      `CHK("pins owned", 1'b0, usb_pins_owned)
      `CHK("reset low power", 1'b1, xcvr_low_power)
      @(posedge core_clk);
      se0 <= 1'b1;
      cyc(SC - 8);
      rd(OTG_STATUS_OFFSET, 32'h0000_0084, "line moving");
      cyc(14);
      rd(OTG_STATUS_OFFSET, 32'h0000_00A4, "line steady");
      for (int k = 0; k < 8; k++) begin
         b_cable <= k[0];
         role_b  <= k[1];
         vbus_mv <= k[2] ? 16'h1388 : 16'h03E8;
         cyc(6);
         rd(OTG_STATUS_OFFSET, {24'h0, k[0], 2'b01, 1'b0, k[2], k[1] & ~k[2], 1'b0,
            ~k[1] & k[2]}, "status table");
      end
      wr(OTG_STATUS_OFFSET, 32'hFFFF_FFFF);
      rd(OTG_STATUS_OFFSET, 32'h0000_00A8, "status write");
      wr(POWER_CTRL_OFFSET, 32'hFFFF_FFFF);
      rd(POWER_CTRL_OFFSET, 32'h0000_001B, "power all ones");
      `CHK("clk gate", 1'b0, usb_clk_gate_en)
      `CHK("low power", 1'b1, xcvr_low_power)
      `CHK("analog on", 1'b1, analog_enable)
      `CHK("pins on", 1'b1, usb_pins_owned)
      wr(POWER_CTRL_OFFSET, 32'h0000_0011);
      cyc(2);
      #1;
      `CHK("clk run", 1'b1, usb_clk_gate_en)
      `CHK("xcvr on", 1'b0, xcvr_low_power)
      act <= 1'b1;
      cyc(6);
      act <= 1'b0;
      cyc(6);
      rd(POWER_CTRL_OFFSET, 32'h0000_0099, "pending held");
      `CHK("sleep held", 1'b1, sleep_block)
      irq_req <= 1'b1;
      cyc(1);
      irq_req <= 1'b0;
      cyc(6);
      rd(POWER_CTRL_OFFSET, 32'h0000_0019, "pending clear");
      `CHK("sleep free", 1'b0, sleep_block)
      wr(POWER_CTRL_OFFSET, 32'h0000_0001);
      act <= 1'b1;
      cyc(6);
      #1;
      `CHK("no guard", 1'b0, sleep_block)
      rd(POWER_CTRL_OFFSET, 32'h0000_0089, "pending unguarded");
      act       <= 1'b0;
      cyc(4);
      irq_req   <= 1'b1;
      busy_core <= 1'b1;
      cyc(1);
      irq_req <= 1'b0;
      wr(POWER_CTRL_OFFSET, 32'h0000_0000);
      cyc(20);
      rd(POWER_CTRL_OFFSET, 32'h0000_0008, "busy core");
      `CHK("pins freed", 1'b0, usb_pins_owned)
      `CHK("analog off", 1'b0, analog_enable)
      busy_core <= 1'b0;
      cyc(12);
      rd(POWER_CTRL_OFFSET, 32'h0000_0000, "busy done");
      wr(POWER_CTRL_OFFSET, 32'h0000_0001);
      wr(POWER_CTRL_OFFSET, 32'h0000_0000);
      rd(POWER_CTRL_OFFSET, 32'h0000_0008, "busy hold");
      act <= 1'b1;
      cyc(12);
      wr(4'h8, 32'hFFFF_FFFF);
      rd(4'h8, 32'h0000_0000, "unmapped");
      rd(POWER_CTRL_OFFSET, 32'h0000_0000, "power after unmapped");
      `CHK("sleep disabled", 1'b0, sleep_block)
      report_and_stop();
   end
endmodule : tb_usb_otg_status_power_ctrl

// ### verif/uosp_cable_model.sv
// cable, transceiver, comparator and usb core stand-in for the status block
// assumes bench commands; every pin changes just after a core_clk edge
`timescale 1ns/1ps
module uosp_cable_model #(
   parameter int SESS_MV = 4000
)(
   // clock
   input  wire logic        core_clk,
   // bench commands
   input  wire logic        b_cable,
   input  wire logic        role_b,
   input  wire logic [15:0] vbus_mv,
   input  wire logic        se0,
   input  wire logic        jst,
   input  wire logic        act,
   input  wire logic        busy_core,
   input  wire logic        irq_req,
   // pins toward the block
   output logic             id_pin,
   output logic             se0_line,
   output logic             j_line,
   output logic             vbus_above_sess,
   output logic             b_role,
   output logic             bus_activity,
   output logic             core_active,
   output logic             act_irq_done
);
   always @(posedge core_clk) begin
      id_pin          <= b_cable;
      vbus_above_sess <= (vbus_mv > 16'(SESS_MV));
      b_role          <= role_b;
      se0_line        <= se0;
      j_line          <= jst;
      bus_activity    <= act;
      core_active     <= busy_core;
      // one cycle pulse per request
      act_irq_done    <= irq_req & ~act_irq_done;
   end
endmodule : uosp_cable_model
